// File: core/raster_pixel_op_control.v
`timescale 1ns/1ps
`include "raster_defines.vh"
// ----------------------------------------------------------------------
// pixel combine control with apb register port
// ----------------------------------------------------------------------
module raster_pixel_op_control (
   input  wire        pclk,            // engine clock
   input  wire        presetn,         // async reset, active low
   input  wire        psel,            // apb select
   input  wire        penable,         // apb enable
   input  wire        pwrite,          // apb direction
   input  wire [11:0] paddr,           // apb byte address
   input  wire [31:0] pwdata,          // apb write data
   output reg  [31:0] prdata,          // apb read data
   output reg         pready,          // apb ready
   output reg         pslverr,         // apb error
   input  wire [31:0] src_dword,       // screen source dword
   input  wire        src_dword_valid, // screen dword offered
   output reg         src_dword_ready, // buffer can take a screen dword
   input  wire        pix_req,         // one destination pixel to process
   input  wire        pix_line_end,    // pixel is the last of its line
   input  wire [31:0] pat_pixel,       // pattern data for the pixel
   input  wire [31:0] dst_pixel,       // destination data for the pixel
   output reg         pix_ready,       // a pixel request is taken
   output reg         res_valid,       // result pulse
   output reg  [31:0] res_pixel,       // result value
   output reg  [3:0]  res_byte_en,     // bytes to write
   output reg         src_line_next    // fetch next source scan line
);

   // -------------------------------------------------------------------
   // register index decode
   // -------------------------------------------------------------------
   function [3:0] reg_index;
      input [11:0] a;
      begin
         case (a)
            `ADDR_POC:    reg_index = 4'h0;
            `ADDR_BG:     reg_index = 4'h1;
            `ADDR_FG:     reg_index = 4'h2;
            `ADDR_CMP:    reg_index = 4'h3;
            `ADDR_DEPTH:  reg_index = 4'h4;
            `ADDR_HOST:   reg_index = 4'h5;
            `ADDR_RESULT: reg_index = 4'h6;
            `ADDR_STATUS: reg_index = 4'h7;
            default:      reg_index = 4'hF;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------
   // pixel mask from the pixel size code
   // -------------------------------------------------------------------
   function [31:0] depth_mask;
      input [1:0] d;
      begin
         case (d)
            2'h0:    depth_mask = 32'h000000FF;
            2'h1:    depth_mask = 32'h0000FFFF;
            2'h2:    depth_mask = 32'h00FFFFFF;
            default: depth_mask = 32'hFFFFFFFF;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   reg  [31:0] ctrl_r;           // pixel_operation_control
   reg  [31:0] ctrl_nxt;
   reg  [31:0] bg_r;             // background colour
   reg  [31:0] fg_r;             // foreground colour
   reg  [31:0] cmp_r;            // source transparency compare value
   reg  [1:0]  depth_r;          // pixel size code
   reg  [31:0] buf_r;            // source dword buffer
   reg  [31:0] buf_nxt;
   reg         buf_valid_r;      // buffer holds data
   reg         buf_valid_nxt;
   reg  [4:0]  ptr_r;            // bit pointer into buffer
   reg  [4:0]  ptr_nxt;
   reg         line_next_nxt;
   reg  [31:0] rd_data;          // read mux
   reg         rd_err;           // unmapped address
   reg  [31:0] src_px;           // chosen source pixel
   reg  [31:0] value;            // pixel value to write
   reg         wr_pix;           // pixel modified at all

   wire [3:0]  wr_idx;           // write target
   wire [3:0]  rd_idx;           // read target
   wire        wr_acc;           // write takes effect
   wire [1:0]  src_sel;          // source select field
   wire [1:0]  sel_nxt;          // source select after this edge
   wire        uses_buf;         // source comes from the dword buffer
   wire        pix_take;         // pixel accepted this edge
   wire [5:0]  need;             // bits consumed per pixel
   wire [5:0]  ptr_sum;          // pointer after the pixel
   wire [31:0] mask;             // pixel width mask
   wire [31:0] ext_color;        // colour from the buffer
   wire        ext_bit;          // bitmap bit from the buffer
   wire [31:0] rop_out;          // truth table result
   wire        src_match;        // source equals compare value
   wire [3:0]  pat_nz;           // pattern byte non-zero

   assign wr_idx   = reg_index(paddr);
   assign rd_idx   = reg_index(paddr);
   assign wr_acc   = psel & penable & pwrite & pready;
   assign src_sel  = ctrl_r[`SRC_SEL_HI:`SRC_SEL_LO];
   assign sel_nxt  = ctrl_nxt[`SRC_SEL_HI:`SRC_SEL_LO];
   assign uses_buf = (src_sel == `SRC_SCREEN) | (src_sel == `SRC_HOST); // RL14
   assign pix_take = pix_req & pix_ready;
   assign mask     = depth_mask(depth_r);
   assign need     = ctrl_r[`EXPAND_BIT] ? 6'h01 :
                     {({1'b0, depth_r} + 3'h1), 3'h0};                // RL8
   assign ptr_sum  = {1'b0, ptr_r} + need;

   // -------------------------------------------------------------------
   // source extraction and combine
   // -------------------------------------------------------------------
   source_extract u_extract (
      .dword   (buf_r),
      .ptr     (ptr_r),
      .mask    (mask),
      .color   (ext_color),
      .bmp_bit (ext_bit)
   );

   boolean_combine u_combine (
      .code   (ctrl_r[`CODE_HI:`CODE_LO]),
      .pat    (pat_pixel),
      .src    (src_px),
      .dst    (dst_pixel),
      .result (rop_out)
   );

   assign src_match = ((src_px ^ cmp_r) & mask) == 32'h00000000;       // RL1

   // pattern bytes that are zero block their byte
   genvar b;
   generate
      for (b = 0; b < 4; b = b + 1) begin : g_pat
         assign pat_nz[b] = pat_pixel[8*b+7:8*b] != 8'h00;           // RL9
      end
   endgenerate

   // -------------------------------------------------------------------
   // pixel decision
   // -------------------------------------------------------------------
   always @* begin
      // source operand by select field, reserved falls back to fill
      if (!uses_buf) begin
         src_px = bg_r;                                               // RL14
      end else if (ctrl_r[`EXPAND_BIT]) begin
         src_px = ext_bit ? fg_r : bg_r;                              // RL8
      end else begin
         src_px = ext_color;
      end
      value  = rop_out;                                               // RL13
      wr_pix = 1'b1;
      // source transparency with its match sense
      if (ctrl_r[`SRC_TR_EN]) begin
         if (ctrl_r[`SRC_TR_MATCH]) begin
            wr_pix = src_match;                                       // RL4
         end else begin
            wr_pix = ~src_match;                                      // RL5
         end
      end
      // bitmap transparency: skip zeros, foreground on ones
      if (ctrl_r[`BMP_TR_BIT]) begin
         value = fg_r;                                                // RL11
         if (!ext_bit) begin
            wr_pix = 1'b0;                                            // RL11
         end
      end
   end

   // -------------------------------------------------------------------
   // buffer, pointer and control next state
   // -------------------------------------------------------------------
   always @* begin
      ctrl_nxt      = ctrl_r;
      buf_nxt       = buf_r;
      buf_valid_nxt = buf_valid_r;
      ptr_nxt       = ptr_r;
      line_next_nxt = 1'b0;
      // software write to the control word
      if (wr_acc && wr_idx == 4'h0) begin
         ctrl_nxt      = pwdata & `POC_RW_MASK;
         buf_valid_nxt = 1'b0;                  // new setup flushes source
         ptr_nxt       = 5'h00;
      end
      // consume source bits for the accepted pixel
      if (pix_take && uses_buf) begin
         if (ptr_sum[5]) begin
            buf_valid_nxt = 1'b0;               // dword used up
            ptr_nxt       = 5'h00;
         end else begin
            ptr_nxt = ptr_sum[4:0];
         end
      end
      // end of destination line
      if (pix_take && pix_line_end) begin
         if (!ctrl_r[`PACKED_BIT]) begin
            line_next_nxt = uses_buf;                                 // RL7
            buf_valid_nxt = 1'b0;                                     // RL7
            ptr_nxt       = 5'h00;                                    // RL7
         end
         // packed mode keeps the leftover bits for the next line   RL6
      end
      // screen dword load
      if (src_dword_ready && src_dword_valid) begin
         buf_nxt       = src_dword;
         buf_valid_nxt = 1'b1;
         ptr_nxt       = 5'h00;
      end
      // host data port: never fails, loaded only for host source while the buffer is empty
      if (wr_acc && wr_idx == 4'h5 && src_sel == `SRC_HOST && !buf_valid_r) begin
         buf_nxt       = pwdata;                                      // RL15
         buf_valid_nxt = 1'b1;
         ptr_nxt       = 5'h00;
      end
   end

   // -------------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------------
   always @* begin
      rd_err = 1'b0;
      case (rd_idx)
         4'h0:    rd_data = ctrl_r;
         4'h1:    rd_data = bg_r;
         4'h2:    rd_data = fg_r;
         4'h3:    rd_data = cmp_r;
         4'h4:    rd_data = {30'h0, depth_r};
         4'h6:    rd_data = res_pixel;
         4'h7:    rd_data = {26'h0, buf_valid_r, ptr_r};
         4'h5:    rd_data = 32'h00000000;      // data port reads zero
         default: begin
            rd_data = 32'h00000000;
            rd_err  = 1'b1;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // apb answer: ready in the access cycle, data captured at setup
   // -------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h00000000 : rd_data;
         pslverr <= rd_err;
      end else begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // configuration registers
   // -------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r  <= `RST_WORD;
         bg_r    <= `RST_WORD;
         fg_r    <= `RST_WORD;
         cmp_r   <= `RST_WORD;
         depth_r <= `RST_DEPTH;
      end else begin
         ctrl_r <= ctrl_nxt;
         if (wr_acc && wr_idx == 4'h1) begin
            bg_r <= pwdata;
         end
         if (wr_acc && wr_idx == 4'h2) begin
            fg_r <= pwdata;
         end
         if (wr_acc && wr_idx == 4'h3) begin
            cmp_r <= pwdata;
         end
         if (wr_acc && wr_idx == 4'h4) begin
            depth_r <= pwdata[1:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // source buffer and handshakes
   // -------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_r           <= 32'h00000000;
         buf_valid_r     <= 1'b0;
         ptr_r           <= 5'h00;
         pix_ready       <= 1'b0;
         src_dword_ready <= 1'b0;
         src_line_next   <= 1'b0;
      end else begin
         buf_r           <= buf_nxt;
         buf_valid_r     <= buf_valid_nxt;
         ptr_r           <= ptr_nxt;
         pix_ready       <= buf_valid_nxt | ~((sel_nxt == `SRC_SCREEN) |
                                              (sel_nxt == `SRC_HOST));
         src_dword_ready <= (sel_nxt == `SRC_SCREEN) & ~buf_valid_nxt;
         src_line_next   <= line_next_nxt;
      end
   end

   // -------------------------------------------------------------------
   // result outputs
   // -------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_valid   <= 1'b0;
         res_pixel   <= 32'h00000000;
         res_byte_en <= 4'h0;
      end else begin
         res_valid <= pix_take;
         if (pix_take) begin
            res_pixel   <= value & mask;
            res_byte_en <= {4{wr_pix}} & {mask[24], mask[16], mask[8], mask[0]} &
                           (ctrl_r[`PAT_TR_BIT] ? pat_nz : 4'hF);    // RL9
         end
      end
   end

endmodule // raster_pixel_op_control

// File: core/raster_defines.vh
// Functional notes
// [RL1] source transparency compares source with compare value
// [RL2] software avoids source transparency at three bytes
// [RL3] source transparency only for non-bitmap sources; the code also applies it to expanded bitmap sources
// [RL4] match sense one: write only matching pixels
// [RL5] match sense zero: write only differing pixels
// [RL6] packed: leftover source dword feeds next line
// [RL7] unpacked: drop leftovers, fetch fresh next line
// [RL8] expand: source is one bit per pixel
// [RL9] pattern transparency: zero pattern bytes left alone
// [RL10] software sets pattern present with pattern transparency
// [RL11] bitmap transparency: skip zeros, foreground on ones
// [RL12] software sets expand with bitmap transparency
// [RL13] low eight bits are the combine code
// [RL14] source select: fill, screen, host, reserved
// [RL15] data port writes never fail, host only
// [RL16] software picks solid fill when code ignores source
// [RL17] combine code is a pattern/source/destination truth table
`ifndef RASTER_DEFINES_VH
`define RASTER_DEFINES_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ADDR_POC       12'h08C
`define ADDR_BG        12'h0C0
`define ADDR_FG        12'h0C4
`define ADDR_CMP       12'h0C8
`define ADDR_DEPTH     12'h0CC
`define ADDR_HOST      12'h0D0
`define ADDR_RESULT    12'h0D4
`define ADDR_STATUS    12'h0D8

// ----------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------
`define SRC_SEL_HI     31
`define SRC_SEL_LO     30
`define SRC_TR_EN      13
`define SRC_TR_MATCH   12
`define PACKED_BIT     11
`define EXPAND_BIT     10
`define PAT_TR_BIT     9
`define BMP_TR_BIT     8
`define CODE_HI        7
`define CODE_LO        0
`define POC_RW_MASK    32'hF800FFFF

// ----------------------------------------------------------------------
// source select codes and reset values
// ----------------------------------------------------------------------
`define SRC_FILL       2'h0
`define SRC_SCREEN     2'h1
`define SRC_HOST       2'h2
`define SRC_RSVD       2'h3
`define RST_WORD       32'h00000000
`define RST_DEPTH      2'h0

`endif

// File: core/boolean_combine.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// per-bit truth table combine of pattern, source and destination
// ----------------------------------------------------------------------
module boolean_combine (
   input  wire [7:0]  code,       // boolean_combine_code
   input  wire [31:0] pat,        // pattern pixel
   input  wire [31:0] src,        // source pixel
   input  wire [31:0] dst,        // destination pixel
   output wire [31:0] result      // combined pixel
);
   genvar i;
   generate
      for (i = 0; i < 32; i = i + 1) begin : g_bit
         // pattern is the top index bit, destination the lowest
         assign result[i] = code[{pat[i], src[i], dst[i]}]; // RL17 RL13
      end
   endgenerate
endmodule // boolean_combine

// File: core/source_extract.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// picks the current pixel or bitmap bit out of the source dword
// ----------------------------------------------------------------------
module source_extract (
   input  wire [31:0] dword,      // buffered source dword
   input  wire [4:0]  ptr,        // bit position of the next pixel
   input  wire [31:0] mask,       // pixel width mask
   output wire [31:0] color,      // colour pixel, low bits first
   output wire        bmp_bit     // bitmap bit at the pointer
);
   wire [31:0] shifted;           // dword aligned to the pointer

   assign shifted = dword >> ptr;
   assign color   = shifted & mask;
   assign bmp_bit = shifted[0];   // RL8
endmodule // source_extract

// File: bench/raster_pixel_op_control_asserts.sv
`timescale 1ns/1ps
`include "raster_defines.vh"
// ------------------------------------------------------------
// port-side checks of the pixel combine control
// ------------------------------------------------------------
module raster_checks (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        src_dword_ready,
   input wire        pix_req,
   input wire        pix_ready,
   input wire [31:0] pat_pixel,
   input wire        res_valid,
   input wire [31:0] res_pixel,
   input wire [3:0]  res_byte_en,
   input wire        src_line_next
);
   reg  [31:0] ctrl_r;   // control word as last written
   reg  [1:0]  depth_r;  // pixel size as last written
   reg  [31:0] fg_r;     // foreground as last written
   reg  [3:0]  patnz_r;  // nonzero pattern bytes of the taken pixel
   wire        wr_done = psel && penable && pready && pwrite;
   wire        mapped  = (paddr == `ADDR_POC) || (paddr >= `ADDR_BG &&
                         paddr <= `ADDR_STATUS && paddr[1:0] == 2'h0);
   wire [31:0] mask    = 32'hFFFFFFFF >> {~depth_r, 3'h0};
   wire [3:0]  bmask   = 4'hF >> ~depth_r;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // shadow of the registers the checks depend on
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r  <= 32'h0;
         depth_r <= 2'h0;
         fg_r    <= 32'h0;
         patnz_r <= 4'h0;
      end else begin
         if (wr_done && paddr == `ADDR_POC) ctrl_r <= pwdata;
         if (wr_done && paddr == `ADDR_DEPTH) depth_r <= pwdata[1:0];
         if (wr_done && paddr == `ADDR_FG) fg_r <= pwdata;
         if (pix_req && pix_ready)
            patnz_r <= {|pat_pixel[31:24], |pat_pixel[23:16], |pat_pixel[15:8], |pat_pixel[7:0]};
      end
   end

   apb_ready_a: assert property (psel && !penable |=> pready && penable)
      else $error("no single access cycle after setup");
   port_error_a: assert property (pready |-> pslverr == !mapped)
      else $error("error response does not match address map");
   read_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access cycle");
   pix_answer_a: assert property (pix_req && pix_ready |=> res_valid)
      else $error("pixel result missing one cycle after request");
   res_cause_a: assert property (res_valid |-> $past(pix_req && pix_ready))
      else $error("result without a taken pixel");
   size_limit_a: assert property (res_valid |->
      (res_pixel & ~mask) == 32'h0 && (res_byte_en & ~bmask) == 4'h0)
      else $error("result wider than pixel size");
   pat_hole_a: assert property (res_valid && ctrl_r[`PAT_TR_BIT] |->
      (res_byte_en & ~patnz_r) == 4'h0)
      else $error("byte written under zero pattern byte");
   bmp_fg_a: assert property (res_valid && ctrl_r[`BMP_TR_BIT] |->
      res_byte_en == 4'h0 || res_pixel == (fg_r & mask))
      else $error("bitmap transparency wrote other than foreground");
   line_drop_a: assert property (src_line_next |->
      !ctrl_r[`PACKED_BIT] && ctrl_r[31] != ctrl_r[30])
      else $error("line fetch pulse in packed or fill mode");
   screen_ready_a: assert property (src_dword_ready |-> ctrl_r[31:30] == `SRC_SCREEN)
      else $error("screen buffer ready without screen source");
endmodule // raster_checks

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "raster_defines.vh"
module tb_top;
   reg         pclk, presetn, psel, penable, pwrite, src_dword_valid, pix_req, pix_line_end;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, src_dword, pat_pixel, dst_pixel, rd, v, w, bg, fg;
   reg  [7:0]  c;
   reg         er;
   wire [31:0] prdata, res_pixel;
   wire [3:0]  res_byte_en;
   wire        pready, pslverr, src_dword_ready, pix_ready, res_valid, src_line_next;
   integer     fail_count, num_checks, i, k, cyc = 0, lines = 0;

   raster_pixel_op_control DUT (.*);

   // clock source
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // cycle limit and line fetch pulse counter
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (src_line_next === 1'b1) lines = lines + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         results;
      end
   end

   task chk(input string nm, input [31:0] e, input [31:0] g);
      num_checks = num_checks + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer, held until pready
   task apb(input w_, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w_; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0; pwdata <= ~d;
   endtask

   task ctl(input [31:0] cw, input [1:0] dp);
      apb(1'b1, `ADDR_DEPTH, {30'h0, dp});
      apb(1'b1, `ADDR_POC, cw);
   endtask

   // offer one screen dword until taken
   task sdw(input [31:0] d);
      @(posedge pclk);
      src_dword <= d; src_dword_valid <= 1'b1;
      do @(posedge pclk); while (src_dword_ready !== 1'b1);
      src_dword_valid <= 1'b0; src_dword <= ~d;
   endtask

   // one pixel request, result sampled in the answer cycle
   task pix(input [31:0] p, input [31:0] d, input le);
      @(posedge pclk);
      pix_req <= 1'b1; pat_pixel <= p; dst_pixel <= d; pix_line_end <= le;
      do @(posedge pclk); while (pix_ready !== 1'b1);
      pix_req <= 1'b0; pat_pixel <= ~p; dst_pixel <= ~d;
      @(negedge pclk);
      chk("res_valid", 1, res_valid);
   endtask

   function [31:0] tt(input [7:0] cd, input [31:0] p, input [31:0] s, input [31:0] d);
      integer b;
      for (b = 0; b < 32; b = b + 1) tt[b] = cd[{p[b], s[b], d[b]}];
   endfunction

   task results;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      fail_count = 0; num_checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 12'h0; pwdata = 0; src_dword = 0; src_dword_valid = 1'b0;
      pix_req = 1'b0; pix_line_end = 1'b0; pat_pixel = 0; dst_pixel = 0;
      v = $urandom(19911);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // register port
      apb(1'b0, `ADDR_POC, 0); chk("ctrl reset", 0, rd);
      v = $urandom; apb(1'b1, `ADDR_POC, v); apb(1'b0, `ADDR_POC, 0);
      chk("ctrl readback", v & `POC_RW_MASK, rd);
      apb(1'b1, `ADDR_RESULT, v); chk("ro write err", 0, er);
      apb(1'b0, 12'h100, 0); chk("unmapped err", 1, er); chk("unmapped data", 0, rd);
      ctl({`SRC_FILL, 30'h0}, 2'h3);
      apb(1'b1, `ADDR_HOST, v); chk("host port err", 0, er);
      apb(1'b0, `ADDR_STATUS, 0); chk("host ignored", 0, rd);
      // truth table over fill and reserved select, every size
      for (i = 0; i < 12; i = i + 1) begin
         c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : $urandom;
         bg = $urandom; apb(1'b1, `ADDR_BG, bg);
         ctl({(i[2] ? `SRC_RSVD : `SRC_FILL), 22'h0, c}, i[1:0]);
         v = $urandom; w = $urandom; pix(v, w, 1'b0);
         chk("fill pixel", tt(c, v, bg, w) & (32'hFFFFFFFF >> {~i[1:0], 3'h0}), res_pixel);
         chk("fill bytes", 4'hF >> ~i[1:0], res_byte_en);
      end
      // screen source, unpacked then packed line end
      for (i = 0; i < 2; i = i + 1) begin
         ctl({`SRC_SCREEN, 30'h0} | (i << `PACKED_BIT) | 8'hCC, 2'h0);
         v = $urandom; sdw(v);
         pix(0, 0, 1'b0); chk("screen px0", v[7:0], res_pixel);
         k = lines; pix(0, 0, 1'b1); chk("screen px1", v[15:8], res_pixel);
         repeat (3) @(posedge pclk);
         chk("line fetch", (i == 1) ? k : k + 1, lines);
         if (i == 1) begin
            pix(0, 0, 1'b0); chk("packed carry", v[23:16], res_pixel);
         end else begin
            w = $urandom; sdw(w);
            pix(0, 0, 1'b0); chk("fresh line", w[7:0], res_pixel);
         end
      end
      // bitmap expansion, lowest bit first
      fg = $urandom; bg = $urandom; apb(1'b1, `ADDR_FG, fg); apb(1'b1, `ADDR_BG, bg);
      ctl({`SRC_SCREEN, 30'h0} | (1 << `EXPAND_BIT) | 8'hCC, 2'h3);
      sdw(32'h5);
      for (k = 0; k < 3; k = k + 1) begin
         pix(0, 0, 1'b0); chk("expand", (k == 1) ? bg : fg, res_pixel);
      end
      // source transparency, both match senses
      for (i = 0; i < 2; i = i + 1) begin
         v = $urandom; apb(1'b1, `ADDR_CMP, {16'h0, v[15:0]});
         ctl({`SRC_SCREEN, 30'h0} | (1 << `SRC_TR_EN) | (i << `SRC_TR_MATCH) | 8'hCC,
             2'h1);
         sdw({~v[15:0], v[15:0]});
         pix(0, 0, 1'b0); chk("match bytes", i ? 4'h3 : 4'h0, res_byte_en);
         pix(0, 0, 1'b0); chk("differ bytes", i ? 4'h0 : 4'h3, res_byte_en);
      end
      // host source through the data port
      ctl({`SRC_HOST, 30'h0} | 8'hCC, 2'h3);
      v = $urandom; apb(1'b1, `ADDR_HOST, v); chk("host write err", 0, er);
      pix(0, 0, 1'b0); chk("host pixel", v, res_pixel);
      apb(1'b0, `ADDR_RESULT, 0); chk("result reg", v, rd);
      // pattern transparency then bitmap transparency
      ctl((1 << 29) | (1 << `PAT_TR_BIT) | 8'hF0, 2'h3);
      pix(32'h00FF0000, 0, 1'b0); chk("pat bytes", 4'h4, res_byte_en);
      ctl({`SRC_SCREEN, 30'h0} | (1 << `EXPAND_BIT) | (1 << `BMP_TR_BIT) | 8'hCC,
          2'h3);
      sdw(32'h2);
      pix(0, 0, 1'b0); chk("bmp skip", 4'h0, res_byte_en);
      pix(0, 0, 1'b0); chk("bmp fg", fg, res_pixel);
      chk("bmp bytes", 4'hF, res_byte_en);
      results;
   end
endmodule // tb_top

bind raster_pixel_op_control raster_checks u_chk (.*);
